// File: pkg/ir_carrier_pkg.sv
// Functional notes
// - output follows enable pair truth table
// - staged enable writable, active enable read-only
// - envelope match synchronised into envelope_sync_irq
// - staged copies to active two clocks later
// - low compare first; match toggles, clears, switches
// - high compare match toggles, clears, switches back
// - counting starts with carrier at default level
// - clearing run enable stops carrier timer
// - period N+M+2 clocks, high M+1
// - high compare write takes three count clocks
// - carrier starts at next carrier rising edge
// - clearing active enable never truncates a high phase
// - low compare sets low width, high sets high
// - new high value lands at old match, or at once while stopped
package ir_carrier_pkg;
  localparam int          CNT_W         = 8;
  localparam logic [7:0]  COUNT_RESET   = 8'h00;
  localparam logic [7:0]  COMPARE_RESET = 8'h00;
  localparam int          CLK_HZ        = 50_000_000;
  localparam int          HIGH_XFER_CNT = 3;
  localparam int          ENABLE_XFER   = 2;
  localparam logic [2:0]  DIV_SEL_RESET = 3'h0;
endpackage

// File: pkg/count_tick_if.sv
`timescale 1ns/1ps
interface count_tick_if;
  logic       tick;     // one-cycle count clock enable
  logic [2:0] sel;      // divider select
  modport src (output tick, input sel);
  modport dst (input tick, output sel);
endinterface

// File: verilog/count_divider.sv
`timescale 1ns/1ps
module count_divider (
  input  wire logic  clk,      // system clock
  input  wire logic  sys_rst,  // synchronous reset, high
  input  wire logic  run,      // divider runs while high
  count_tick_if.src  ct        // tick out, select in
);
  typedef struct packed {
    logic [6:0] cnt;
    logic       tick;
  } div_state_s;

  div_state_s st;
  div_state_s next_st;

  // select n gives one tick every 2**n system clocks
  always_comb begin
    logic [6:0] lim;
    lim = 7'((7'h01 << ct.sel) - 7'h01);
    next_st = st;
    next_st.tick = 1'b0;
    if (!run) begin
      next_st.cnt = 7'h00;
    end else if (st.cnt >= lim) begin
      next_st.cnt  = 7'h00;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 7'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ct.tick = st.tick;
endmodule // count_divider

// File: verilog/ir_carrier_generator.sv
`timescale 1ns/1ps
module ir_carrier_generator #(
  parameter int CNT_W = ir_carrier_pkg::CNT_W
) (
  input  wire logic             clk,                   // 50 MHz clock
  input  wire logic             sys_rst,               // sync reset, high
  input  wire logic [2:0]       count_clock_select,    // count clock divider
  input  wire logic             counter_run_enable,    // start/stop counter
  input  wire logic             envelope_timer_enable, // envelope counter on
  input  wire logic             remote_output_enable,  // carrier gating on
  input  wire logic [CNT_W-1:0] low_width_compare,     // low width value N
  input  wire logic [CNT_W-1:0] high_width_wdata,      // high width value M
  input  wire logic             high_width_we,         // high width write
  input  wire logic             staged_wdata,          // staged enable data
  input  wire logic             staged_we,             // staged enable write
  input  wire logic             envelope_match_irq,    // envelope match pulse
  output logic                  carrier_enable_staged, // staged enable bit
  output logic                  carrier_enable_active, // active enable bit
  output logic [CNT_W-1:0]      high_width_compare,    // active high compare
  output logic                  envelope_sync_irq,     // synced envelope irq
  output logic                  envelope_run,          // envelope timer run
  output logic                  compare_match_irq,     // match pulse
  output logic                  carrier_output_pin     // output level
);
  count_tick_if ct ();

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             sel_high;
    logic             carrier;
    logic             out;
    logic             first_tick;
    logic [CNT_W-1:0] high_active;
    logic [CNT_W-1:0] high_latch;
    logic             high_pending;
    logic [1:0]       high_age;
    logic             env_seen;
    logic             sync_irq;
    logic [1:0]       xfer_cnt;
    logic             staged;
    logic             active;
    logic             match_irq;
    logic             env_run;
    logic             gate;
  } gen_state_s;

  gen_state_s st;
  gen_state_s next_st;

  assign ct.sel = count_clock_select;

  count_divider u_div (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (counter_run_enable),
    .ct      (ct)
  );

  always_comb begin
    logic             match;
    logic [CNT_W-1:0] cmp;
    next_st = st;
    next_st.match_irq = 1'b0;
    next_st.env_run = envelope_timer_enable;
    cmp = st.sel_high ? st.high_active : low_width_compare;
    match = (st.count == cmp) && !st.first_tick;

    // write side: staged bit and latched high value, any time
    if (staged_we) begin
      next_st.staged = staged_wdata;
    end
    if (high_width_we) begin
      next_st.high_latch   = high_width_wdata;
      next_st.high_pending = 1'b1;
      next_st.high_age     = 2'h0;
    end

    // an envelope event waits here for the next count tick
    if (envelope_match_irq) begin
      next_st.env_seen = 1'b1;
    end

    if (!counter_run_enable) begin
      next_st.count      = ir_carrier_pkg::COUNT_RESET;
      next_st.sel_high   = 1'b0;
      next_st.carrier    = 1'b0;
      next_st.first_tick = 1'b1;
      next_st.xfer_cnt   = 2'h0;
      next_st.sync_irq   = 1'b0;
      // while stopped, the high value loads straight through
      if (high_width_we) begin
        next_st.high_active  = high_width_wdata;
        next_st.high_pending = 1'b0;
      end
    end else if (ct.tick) begin
      // first tick is masked so the carrier holds its default
      next_st.first_tick = 1'b0;
      if (st.first_tick) begin
        next_st.count = ir_carrier_pkg::COUNT_RESET;
      end else if (match) begin
        next_st.count     = ir_carrier_pkg::COUNT_RESET;
        next_st.carrier   = ~st.carrier;
        next_st.sel_high  = ~st.sel_high;
        next_st.match_irq = 1'b1;
        // pending value moves only at old match and when aged enough
        if (st.sel_high && st.high_pending && !high_width_we
            && st.high_age == 2'(ir_carrier_pkg::HIGH_XFER_CNT - 1)) begin
          next_st.high_active  = st.high_latch;
          next_st.high_pending = 1'b0;
        end
      end else begin
        next_st.count = CNT_W'(st.count + 1'b1);
      end
      if (st.high_pending && !high_width_we
          && st.high_age != 2'(ir_carrier_pkg::HIGH_XFER_CNT - 1)) begin
        next_st.high_age = st.high_age + 2'h1;
      end

      // envelope event is presented on a count tick
      next_st.sync_irq = st.env_seen || envelope_match_irq;
      next_st.env_seen = 1'b0;

      // strobe lasts one tick, so a set flag here is its rising edge;
      // the copy lands on the second tick after it
      if (st.sync_irq) begin
        next_st.xfer_cnt = 2'h1;
      end else if (st.xfer_cnt == 2'(ir_carrier_pkg::ENABLE_XFER - 1)) begin
        next_st.active   = st.staged;
        next_st.xfer_cnt = 2'h0;
      end
    end

    // gate opens only as the carrier rises and shuts only while it is
    // low, so the active bit alone never cuts a high phase short or starts one mid-phase
    if (!counter_run_enable) begin
      next_st.gate = 1'b0;
    end else if (!st.active && !next_st.carrier) begin
      next_st.gate = 1'b0;
    end else if (st.active && next_st.carrier && !st.carrier) begin
      next_st.gate = 1'b1;
    end

    if (remote_output_enable) begin
      next_st.out = next_st.gate && next_st.carrier;
    end else begin
      next_st.out = next_st.staged;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st            <= '0;
      st.first_tick <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign carrier_enable_staged = st.staged;
  assign carrier_enable_active = st.active;
  assign high_width_compare    = st.high_active;
  assign envelope_sync_irq     = st.sync_irq;
  assign envelope_run          = st.env_run;
  assign compare_match_irq     = st.match_irq;
  assign carrier_output_pin    = st.out;
endmodule // ir_carrier_generator

// File: sim/ir_carrier_checker.sv
`timescale 1ns/1ps
module ir_carrier_checker (
  input wire logic clk,                   // system clock
  input wire logic sys_rst,               // sync reset
  input wire logic counter_run_enable,    // run
  input wire logic envelope_timer_enable, // envelope on
  input wire logic remote_output_enable,  // gating on
  input wire logic envelope_match_irq,    // envelope match
  input wire logic carrier_enable_staged, // staged bit
  input wire logic carrier_enable_active, // active bit
  input wire logic envelope_sync_irq,     // synced strobe
  input wire logic envelope_run,          // envelope run
  input wire logic compare_match_irq,     // match pulse
  input wire logic carrier_output_pin     // output
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // staged held still around the strobe, as software is bound to
  sequence s_sync;
    $rose(envelope_sync_irq) && $stable(carrier_enable_staged)
      ##1 $stable(carrier_enable_staged) [*3];
  endsequence
  sequence s_quiet;
    (!envelope_sync_irq) [*4];
  endsequence
  a_pin_low_off: assert property ((!remote_output_enable &&
    !carrier_enable_staged) [*3] |-> !carrier_output_pin)
    else $error("pin not low with gating off");
  a_pin_high_nrz: assert property ((!remote_output_enable &&
    carrier_enable_staged) [*3] |-> carrier_output_pin)
    else $error("pin not high with staged set");
  a_stop_pin_low: assert property ((remote_output_enable &&
    !counter_run_enable) [*3] |-> !carrier_output_pin)
    else $error("pin not low while stopped");
  a_sync_follows: assert property ($rose(envelope_match_irq) &&
    counter_run_enable |-> ##[1:8] envelope_sync_irq)
    else $error("sync strobe missing");
  a_xfer_done: assert property (s_sync |->
    carrier_enable_active == carrier_enable_staged)
    else $error("active not loaded from staged");
  a_active_hold: assert property (s_quiet |=>
    $stable(carrier_enable_active))
    else $error("active moved without strobe");
  a_match_single: assert property (compare_match_irq |=>
    !compare_match_irq)
    else $error("match pulse too long");
  a_no_match_idle: assert property (!counter_run_enable [*2] |->
    !compare_match_irq)
    else $error("match while stopped");
  a_start_default: assert property ($rose(counter_run_enable) &&
    remote_output_enable |-> (!carrier_output_pin) [*2])
    else $error("carrier left default at start");
  a_env_start: assert property ($rose(envelope_timer_enable) |->
    ##[0:2] envelope_run)
    else $error("envelope timer did not start");
endmodule // ir_carrier_checker
bind ir_carrier_generator ir_carrier_checker i_ir_carrier_checker (
  .clk, .sys_rst, .counter_run_enable, .envelope_timer_enable,
  .remote_output_enable, .envelope_match_irq, .carrier_enable_staged,
  .carrier_enable_active, .envelope_sync_irq, .envelope_run,
  .compare_match_irq, .carrier_output_pin);

// File: sim/envelope_model.sv
`timescale 1ns/1ps
module envelope_model #(
  parameter int PERIOD = 40 // envelope count, well over six carrier clocks
) (
  input  wire logic clk,     // system clock
  input  wire logic sys_rst, // sync reset
  input  wire logic run,     // envelope timer running
  output logic      match    // one-cycle match pulse
);
  logic [7:0] cnt;
  always_ff @(posedge clk) begin
    if (sys_rst || !run) cnt <= 8'h00;
    else cnt <= (cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
  end
  assign match = run && (cnt == 8'(PERIOD - 1));
endmodule // envelope_model

// File: sim/ir_carrier_generator_test.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
  mismatches++; $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module ir_carrier_generator_test;
  logic clk = 0, sys_rst = 1, counter_run_enable = 0;
  logic envelope_timer_enable = 0, remote_output_enable = 0;
  logic high_width_we = 0, staged_wdata = 0, staged_we = 0;
  logic [2:0] count_clock_select = 3'h0;
  logic [7:0] low_width_compare = 8'h02, high_width_wdata = 8'h04;
  logic [7:0] high_width_compare;
  logic carrier_enable_staged, carrier_enable_active, envelope_sync_irq;
  logic envelope_run, compare_match_irq, carrier_output_pin;
  logic envelope_match_irq;
  int mismatches = 0, comparisons = 0, hi, lo, n;
  always #10 clk = ~clk;
  ir_carrier_generator i_ir_carrier_generator (.clk, .sys_rst,
    .count_clock_select, .counter_run_enable, .envelope_timer_enable,
    .remote_output_enable, .low_width_compare, .high_width_wdata,
    .high_width_we, .staged_wdata, .staged_we, .envelope_match_irq,
    .carrier_enable_staged, .carrier_enable_active, .high_width_compare,
    .envelope_sync_irq, .envelope_run, .compare_match_irq,
    .carrier_output_pin);
  envelope_model i_envelope_model (.clk, .sys_rst, .run(envelope_run),
    .match(envelope_match_irq));
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // widths are counted in system clocks, so only ratios are compared
  task automatic wait_pin(logic v, output int c);
    c = 0;
    while (carrier_output_pin !== v) begin
      tick(1);
      c++;
      if (c > 3000) begin mismatches++; end_of_test; end
    end
  endtask
  task automatic stage(logic v);
    staged_wdata <= v; staged_we <= 1'b1; tick(1);
    staged_we <= 1'b0; tick(2);
  endtask
  task automatic write_high(logic [7:0] v);
    high_width_wdata <= v; high_width_we <= 1'b1; tick(1);
    high_width_we <= 1'b0;
  endtask
  task automatic t_levels;
    logic [1:0] k;
    for (int i = 0; i < 3; i++) begin
      k = 2'(i);
      remote_output_enable <= k[1];
      stage(k[0]);
      tick(3);
      `CHK("staged", k[0], carrier_enable_staged)
      `CHK("pin", k == 2'h1, carrier_output_pin)
    end
    $display("t_levels done");
  endtask
  task automatic t_carrier;
    stage(1'b1);
    write_high(8'h04);
    counter_run_enable <= 1'b1; envelope_timer_enable <= 1'b1; tick(1);
    `CHK("pin_start", 1'b0, carrier_output_pin)
    wait_pin(1'b1, n);
    `CHK("active_on", 1'b1, carrier_enable_active)
    wait_pin(1'b0, hi); wait_pin(1'b1, lo);
    `CHK("ratio", hi * 3, lo * 5)
    write_high(8'h07); tick(200);
    `CHK("high_cmp", 8'h07, high_width_compare)
    wait_pin(1'b0, n); wait_pin(1'b1, lo); stage(1'b0);
    wait_pin(1'b0, hi);
    `CHK("full_high", (hi + 3) * 3, lo * 8)
    tick(100);
    `CHK("active_off", 1'b0, carrier_enable_active)
    `CHK("pin_off", 1'b0, carrier_output_pin)
    counter_run_enable <= 1'b0; envelope_timer_enable <= 1'b0; tick(3);
    `CHK("stop_pin", 1'b0, carrier_output_pin)
    `CHK("stop_irq", 1'b0, compare_match_irq)
    $display("t_carrier done");
  endtask
  initial begin
    tick(16);
    sys_rst <= 1'b0;
    tick(2);
    t_levels;
    t_carrier;
    end_of_test;
  end
endmodule // ir_carrier_generator_test
